// file: rtl/cdm_apb_slave.v
// apb slave front end: two wait states, registered answer
// assumes the master holds each request stable until pready is seen high
`timescale 1ns/1ps

module cdm_apb_slave (
  input  wire        core_clk_in,
  input  wire        rstn_in,
  input  wire        ce_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [7:0]  paddr_in,
  input  wire [31:0] rd_data_in,
  input  wire        rd_err_in,
  output wire [5:0]  index_out,
  output wire        wr_done_out,
  output wire        rd_done_out,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out
);

  // --------------------------------------------------------------------
  // one-hot access sequencer
  // --------------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_WAIT = 3'h2;
  localparam [2:0] ST_DONE = 3'h4;

  reg  [2:0] state_q;
  reg  [2:0] state_d;
  wire       access;

  assign access      = psel_in & penable_in;
  assign index_out   = paddr_in[7:2];
  // completion edge is the one where pready is already high
  assign wr_done_out = ce_in & access & state_q[2] & pwrite_in;
  assign rd_done_out = ce_in & access & state_q[2] & ~pwrite_in;

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (access) state_d = ST_WAIT;
      ST_WAIT: state_d = ST_DONE;
      ST_DONE: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q     <= ST_IDLE;
      pready_out  <= 1'h0;
      pslverr_out <= 1'h0;
      prdata_out  <= 32'h0;
    end else if (ce_in) begin
      state_q     <= state_d;
      pready_out  <= state_d[2];
      if (state_d[2]) begin
        // read data sampled one cycle before completion, held with pready
        prdata_out  <= pwrite_in ? 32'h0 : rd_data_in;
        pslverr_out <= rd_err_in;
      end else begin
        prdata_out  <= 32'h0;
        pslverr_out <= 1'h0;
      end
    end
  end

endmodule // cdm_apb_slave

// file: rtl/cdm_regs.vh
// register map and constants for the card dma request mask block
// assumes an apb slave with 32-bit data, one aligned word per register
`ifndef CDM_REGS_VH
`define CDM_REGS_VH

// ----------------------------------------------------------------------
// register indexes, byte address is four times the index
// ----------------------------------------------------------------------
`define CDM_IDX_STATUS       6'h08
`define CDM_IDX_SW_REQUEST   6'h09
`define CDM_IDX_MASTER_CLEAR 6'h0D
`define CDM_IDX_REQ_MASK     6'h0F

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CDM_MASK_BIT         0
`define CDM_STAT_TC_LSB      0
`define CDM_STAT_TC_MSB      3
`define CDM_STAT_REQ_LSB     4
`define CDM_STAT_REQ_MSB     7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CDM_MASK_RESET       1'h1
`define CDM_REG_WIDTH        8

`endif

// file: rtl/cdm_req_gate.v
// card request gate: samples the card request and presence lines
// assumes both inputs are synchronous to core_clk_in
`timescale 1ns/1ps

module cdm_req_gate (
  input  wire core_clk_in,
  input  wire rstn_in,
  input  wire ce_in,
  input  wire card_dreq_in,
  input  wire card_present_in,
  input  wire request_mask_flag_in,
  output reg  dreq_level_out,
  output wire removed_out,
  output reg  gated_req_out
);

  reg present_q;

  // a falling presence line is a removal
  assign removed_out = ce_in & present_q & ~card_present_in;

  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      present_q      <= 1'h0;
      dreq_level_out <= 1'h0;
      gated_req_out  <= 1'h0;
    end else if (ce_in) begin
      present_q      <= card_present_in;
      dreq_level_out <= card_dreq_in;
      // masked requests never reach the transfer logic
      gated_req_out  <= card_dreq_in & ~request_mask_flag_in
                        & card_present_in;
    end
  end

endmodule // cdm_req_gate

// file: rtl/cdm_top.v
// card dma request mask block: register file, mask flag and request gating
// assumes an apb master on core_clk_in and card lines synchronous to it
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "cdm_regs.vh"

module cdm_top (
  input  wire        core_clk_in,
  input  wire        rstn_in,
  input  wire        ce_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [7:0]  paddr_in,
  input  wire [31:0] pwdata_in,
  input  wire [3:0]  pstrb_in,
  output wire [31:0] prdata_out,
  output wire        pready_out,
  output wire        pslverr_out,
  input  wire        card_dreq_in,
  input  wire        card_present_in,
  input  wire        xfer_tc_in,
  output reg         service_req_out,
  output reg         sw_req_out,
  output reg         master_clear_out,
  output reg         request_mask_flag_out
);

  // --------------------------------------------------------------------
  // bus front end
  // --------------------------------------------------------------------
  wire [5:0]  index;
  wire        wr_done;
  wire        rd_done;
  reg  [31:0] rd_data;
  reg         rd_err;

  cdm_apb_slave u_apb (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .ce_in       (ce_in),
    .psel_in     (psel_in),
    .penable_in  (penable_in),
    .pwrite_in   (pwrite_in),
    .paddr_in    (paddr_in),
    .rd_data_in  (rd_data),
    .rd_err_in   (rd_err),
    .index_out   (index),
    .wr_done_out (wr_done),
    .rd_done_out (rd_done),
    .prdata_out  (prdata_out),
    .pready_out  (pready_out),
    .pslverr_out (pslverr_out)
  );

  // --------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------
  wire hit_status;
  wire hit_sw_req;
  wire hit_mclr;
  wire hit_mask;
  wire lane0;

  assign hit_status = (index == `CDM_IDX_STATUS);
  assign hit_sw_req = (index == `CDM_IDX_SW_REQUEST);
  assign hit_mclr   = (index == `CDM_IDX_MASTER_CLEAR);
  assign hit_mask   = (index == `CDM_IDX_REQ_MASK);
  // all registers are one byte wide, so only lane 0 carries data
  assign lane0      = pstrb_in[0];

  wire wr_mask;
  wire wr_sw_req;
  wire mclr;
  wire rd_status;

  assign wr_mask   = wr_done & hit_mask & lane0;
  assign wr_sw_req = wr_done & hit_sw_req & lane0;
  // master clear acts on any write, whatever its data or strobes
  assign mclr      = wr_done & hit_mclr;
  assign rd_status = rd_done & hit_status;

  // --------------------------------------------------------------------
  // card side sampling
  // --------------------------------------------------------------------
  wire dreq_level;
  wire removed;
  wire gated_req;

  cdm_req_gate u_gate (
    .core_clk_in          (core_clk_in),
    .rstn_in              (rstn_in),
    .ce_in                (ce_in),
    .card_dreq_in         (card_dreq_in),
    .card_present_in      (card_present_in),
    .request_mask_flag_in (request_mask_flag_out),
    .dreq_level_out       (dreq_level),
    .removed_out          (removed),
    .gated_req_out        (gated_req)
  );

  // --------------------------------------------------------------------
  // request mask flag
  // --------------------------------------------------------------------
  // removal wins over a software clear in the same cycle, so a card
  // pulled during the write never leaves the channel open
  reg mask_d;

  always @* begin
    mask_d = request_mask_flag_out;
    if (wr_mask)
      mask_d = pwdata_in[`CDM_MASK_BIT];
    if (mclr)
      mask_d = `CDM_MASK_RESET;
    if (removed)
      mask_d = 1'h1;
  end

  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      request_mask_flag_out <= `CDM_MASK_RESET;
    end else if (ce_in) begin
      request_mask_flag_out <= mask_d;
    end
  end

  // --------------------------------------------------------------------
  // terminal count flag
  // --------------------------------------------------------------------
  // cleared by a status read or master clear; a new count in the same
  // cycle wins so it is never lost
  reg tc_q;

  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tc_q <= 1'h0;
    end else if (ce_in) begin
      if (xfer_tc_in)
        tc_q <= 1'h1;
      else if (rd_status | mclr)
        tc_q <= 1'h0;
    end
  end

  // --------------------------------------------------------------------
  // software request
  // --------------------------------------------------------------------
  // any write with lane 0 strobed arms it; it stands until master clear or removal
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sw_req_out <= 1'h0;
    end else if (ce_in) begin
      if (mclr | removed)
        sw_req_out <= 1'h0;
      else if (wr_sw_req)
        sw_req_out <= 1'h1;
    end
  end

  // --------------------------------------------------------------------
  // outputs toward the transfer logic
  // --------------------------------------------------------------------
  // gated_req already reflects the mask; it is held low across a clear
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      service_req_out  <= 1'h0;
      master_clear_out <= 1'h0;
    end else if (ce_in) begin
      service_req_out  <= gated_req & ~request_mask_flag_out
                          & ~mclr;
      master_clear_out <= mclr;
    end
  end

  // --------------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------------
  // the four request bits repeat the single socket's line, one per slot
  wire [3:0] req_bits;
  wire [3:0] tc_bits;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_stat
      assign req_bits[g] = dreq_level;
      assign tc_bits[g]  = tc_q;
    end
  endgenerate

  always @* begin
    rd_data = 32'h0;
    rd_err  = 1'h0;
    if (hit_status)
      rd_data[`CDM_STAT_REQ_MSB:`CDM_STAT_TC_LSB] = {req_bits, tc_bits};
    else if (hit_mask)
      rd_data[`CDM_MASK_BIT] = request_mask_flag_out;
    else if (hit_sw_req | hit_mclr)
      rd_data = 32'h0;
    else
      rd_err = 1'h1;
  end

endmodule // cdm_top

// file: testbench/cdm_card_model.sv
// card side model: drives request and presence lines of one socket
// assumes commands from the bench, lines change just after a rising edge
`timescale 1ns/1ps
module cdm_card_model (
  input  wire logic clk_in,
  input  wire logic rstn_in,
  input  wire logic dreq_cmd_in,
  input  wire logic present_cmd_in,
  output logic      card_dreq_out,
  output logic      card_present_out
);
  // ------------------------------------------------------------
  // lines
  // ------------------------------------------------------------
  // a removed card no longer drives its request, so it falls low
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      card_dreq_out    <= 1'b0;
      card_present_out <= 1'b0;
    end else begin
      card_present_out <= present_cmd_in;
      card_dreq_out    <= dreq_cmd_in & present_cmd_in;
    end
  end
endmodule // cdm_card_model

// file: testbench/cdm_top_assertions.sv
// checker for cdm_top: request gating, mask flag and register reads
// assumes ce_in high and a master that keeps apb ordering
`timescale 1ns/1ps
`include "cdm_regs.vh"
module cdm_top_chk (
  input wire        core_clk_in, rstn_in, ce_in, psel_in, penable_in, pwrite_in,
  input wire [7:0]  paddr_in,
  input wire [31:0] pwdata_in,
  input wire [3:0]  pstrb_in,
  input wire [31:0] prdata_out,
  input wire        pready_out, pslverr_out, card_dreq_in, card_present_in, xfer_tc_in,
  input wire        service_req_out, sw_req_out, master_clear_out, request_mask_flag_out
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  wire acc = pready_out && psel_in && penable_in;
  wire [5:0] idx = paddr_in[7:2];
  sequence s_masked; request_mask_flag_out [*3]; endsequence
  sequence s_live; (card_dreq_in && card_present_in && !request_mask_flag_out) [*3]; endsequence
  property p_rst_mask; $rose(rstn_in) |-> request_mask_flag_out; endproperty
  a_rst_mask: assert property (p_rst_mask) else $error("mask not set after reset");
  property p_masked; s_masked |-> !service_req_out; endproperty
  a_masked: assert property (p_masked) else $error("request passed while masked");
  property p_live; s_live |-> service_req_out; endproperty
  a_live: assert property (p_live) else $error("request not serviced");
  property p_removal; $fell(card_present_in) |-> ##[1:2] request_mask_flag_out; endproperty
  a_removal: assert property (p_removal) else $error("removal left mask clear");
  property p_rd_zero; acc && !pwrite_in && idx == `CDM_IDX_REQ_MASK
    |-> prdata_out[31:1] == 31'h0 && prdata_out[0] == request_mask_flag_out; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("mask read wrong");
  property p_wr_mask; acc && pwrite_in && idx == `CDM_IDX_REQ_MASK && pstrb_in[0]
    && card_present_in && $stable(card_present_in)
    |=> request_mask_flag_out == $past(pwdata_in[0]); endproperty
  a_wr_mask: assert property (p_wr_mask) else $error("mask write wrong");
  property p_mclr; acc && pwrite_in && idx == `CDM_IDX_MASTER_CLEAR
    |=> request_mask_flag_out && master_clear_out ##1 !master_clear_out; endproperty
  a_mclr: assert property (p_mclr) else $error("master clear ignored");
  property p_stat; acc && !pwrite_in && idx == `CDM_IDX_STATUS && $stable(card_dreq_in)
    && $past(card_dreq_in, 2) == card_dreq_in |-> prdata_out[7:4] == {4{card_dreq_in}};
  endproperty
  a_stat: assert property (p_stat) else $error("status request bits wrong");
  property p_one; pready_out |=> !pready_out; endproperty
  a_one: assert property (p_one) else $error("pready longer than one cycle");
endmodule // cdm_top_chk
bind cdm_top cdm_top_chk u_cdm_top_chk (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
  .ce_in(ce_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .card_dreq_in(card_dreq_in),
  .card_present_in(card_present_in), .xfer_tc_in(xfer_tc_in),
  .service_req_out(service_req_out), .sw_req_out(sw_req_out),
  .master_clear_out(master_clear_out), .request_mask_flag_out(request_mask_flag_out));

// file: testbench/cdm_top_tb.sv
// testbench for cdm_top: apb register tasks and card line scenarios
// assumes the card model and checker files compiled before this one
`timescale 1ns/1ps
`include "cdm_regs.vh"
module cdm_top_tb;
  logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, dcmd = 0, pcmd = 0, tc = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, dreq, pres, svc, swr, mclr, mflag, e;
  integer err_count = 0, n_compared = 0;
  always #10 clk = ~clk;
  cdm_top u_cdm_top (.core_clk_in(clk), .rstn_in(rstn), .ce_in(1'b1), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .card_dreq_in(dreq), .card_present_in(pres), .xfer_tc_in(tc),
    .service_req_out(svc), .sw_req_out(swr), .master_clear_out(mclr),
    .request_mask_flag_out(mflag));
  cdm_card_model u_cdm_card_model (.clk_in(clk), .rstn_in(rstn), .dreq_cmd_in(dcmd),
    .present_cmd_in(pcmd), .card_dreq_out(dreq), .card_present_out(pres));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic apb(input logic w, input logic [5:0] i, input logic [31:0] d);
    integer n;
    begin
      n = 0;
      psel <= 1; pen <= 0; pwr <= w; paddr <= {i, 2'b00}; pwdata <= d; pstrb <= 4'hF;
      @(posedge clk);
      pen <= 1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 50) begin n = n + 1; @(posedge clk); end
      if (n >= 50) begin
        err_count = err_count + 1;
        $display("MISMATCH t=%0t no pready on index %h", $time, i);
      end
      rd = prdata;
      e = pslverr;
      psel <= 0; pen <= 0;
      @(posedge clk);
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task automatic results;
    begin
      $display("compared %0d errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin #200000; err_count = err_count + 1; results; end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1; pcmd <= 1; dcmd <= 1;
    apb(0, `CDM_IDX_REQ_MASK, 0); chk(rd, 32'h1);
    repeat (4) @(posedge clk); chk(svc, 0);
    apb(1, `CDM_IDX_REQ_MASK, 32'hFFFF_FFFE); apb(0, `CDM_IDX_REQ_MASK, 0);
    chk(rd, 32'h0);
    repeat (4) @(posedge clk); chk(svc, 1);
    apb(0, `CDM_IDX_STATUS, 0); chk(rd[7:4], 4'hF);
    apb(1, `CDM_IDX_REQ_MASK, 32'h1); repeat (4) @(posedge clk); chk(svc, 0);
    apb(0, `CDM_IDX_STATUS, 0); chk(rd[7:4], 4'hF);
    apb(1, `CDM_IDX_REQ_MASK, 32'h0); dcmd <= 0;
    repeat (4) @(posedge clk); chk(svc, 0);
    pcmd <= 0; repeat (4) @(posedge clk); chk(mflag, 1);
    pcmd <= 1; dcmd <= 1; repeat (4) @(posedge clk); chk(svc, 0);
    apb(1, `CDM_IDX_REQ_MASK, 32'h0); apb(1, `CDM_IDX_SW_REQUEST, 32'h1);
    chk(swr, 1); tc <= 1; @(posedge clk); tc <= 0;
    apb(0, `CDM_IDX_STATUS, 0); chk(rd[3:0], 4'hF);
    apb(0, `CDM_IDX_STATUS, 0); chk(rd[3:0], 4'h0);
    apb(1, `CDM_IDX_MASTER_CLEAR, 32'h0); chk(mflag, 1);
    chk(swr, 0); repeat (4) @(posedge clk); chk(svc, 0);
    apb(0, 6'h01, 0); chk(rd, 32'h0); chk({31'h0, e}, 32'h1);
    results;
  end
endmodule // cdm_top_tb
